// ---- core/lip_pkg.sv ----
// lip_pkg: constants and carriers for the indicator led pwm blinker
// assumes a 10 MHz system clock and a 32-bit apb register port
package lip_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_HEAR_THROUGH_LED_CONFIG = 8'h08;
  localparam logic [7:0] IDX_QUIETING_LED_CONFIG = 8'h09;
  localparam logic [7:0] IDX_OPERATING_MODE = 8'h10;
  localparam logic [7:0] IDX_LED_STATUS = 8'h11;
  localparam logic [7:0] RST_LED_CONFIG = 8'h00;
  localparam logic [1:0] RST_OPERATING_MODE = 2'h0;
  // field positions
  localparam int HT_DUTY_LSB = 0;
  localparam int HT_PATTERN_LSB = 2;
  localparam int Q_DUTY_LSB = 0;
  localparam int Q_PATTERN_LSB = 2;
  localparam int THIRD_SEL_LSB = 5;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PWM_PERIOD_NS = 18000;
  localparam int PWM_QUARTER_ON_NS = 4000;
  localparam int PWM_HALF_ON_NS = 9000;
  localparam logic [7:0] PWM_PERIOD_CYC = 8'(PWM_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [7:0] PWM_QUARTER_CYC = 8'(PWM_QUARTER_ON_NS / CLK_PERIOD_NS);
  localparam logic [7:0] PWM_HALF_CYC = 8'(PWM_HALF_ON_NS / CLK_PERIOD_NS);
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEFAULT = MS_NS / CLK_PERIOD_NS;
  localparam logic [11:0] BLINK_ON_MS = 12'h050;
  localparam logic [11:0] Q_OFF1_MS = 12'h3E8;
  localparam logic [11:0] Q_OFF2_MS = 12'h5DC;
  localparam logic [11:0] Q_OFF3_MS = 12'h9C4;
  localparam logic [1:0] DUTY_OFF = 2'h0;
  localparam logic [1:0] DUTY_QUARTER = 2'h1;
  localparam logic [1:0] DUTY_HALF = 2'h2;
  localparam logic [1:0] DUTY_FULL = 2'h3;
  localparam logic [1:0] THIRD_DARK = 2'h0;
  localparam logic [1:0] THIRD_AS_QUIETING = 2'h1;
  localparam logic [1:0] THIRD_AS_HEAR = 2'h2;
  localparam logic [1:0] THIRD_ALWAYS = 2'h3;

  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_QUIETING,
    MODE_HEAR_THROUGH,
    MODE_THIRD
  } lip_mode_e;

  typedef struct packed {
    lip_mode_e mode;
    logic [7:0] hear_through_led_config;
    logic [7:0] quieting_led_config;
  } lip_cfg_s;
endpackage

// ---- core/lip_led_blinker.sv ----
// lip_led_blinker: apb slave, pwm and blink timing for the led current sink
// assumes apb master on the same clock; inputs synchronous to clock
//
// Behaviour
// - brightness pwm period is 18 us, all duties derived from it
// - quieting mode duty field: off, 4/14 us, 9/9 us, full on
// - hear-through mode has its own duty field with same four encodings
// - hear-through pattern n: zero steady on, else 80 ms active then n*80 ms dark
// - quieting pattern: steady, or 80 ms on then 1 s, 1.5 s, 2.5 s off
// - third mode select: dark, quieting pattern, hear-through pattern, always active
// - third mode brightness is fixed quarter duty, 4 us on of 18 us, while lit
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lip_led_blinker #(
  parameter int MS_CYCLES = lip_pkg::MS_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic led_current_sink
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [11:0] idx_addr(input logic [7:0] idx);
    idx_addr = {2'h0, idx, 2'h0};
  endfunction

  function automatic logic pwm_high(input logic [1:0] duty, input logic [7:0] cnt);
    case (duty)
      lip_pkg::DUTY_QUARTER: pwm_high = (cnt < lip_pkg::PWM_QUARTER_CYC);
      lip_pkg::DUTY_HALF: pwm_high = (cnt < lip_pkg::PWM_HALF_CYC);
      lip_pkg::DUTY_FULL: pwm_high = 1'b1;
      default: pwm_high = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb register file
  lip_pkg::lip_cfg_s cfg_r, cfg_nxt;
  logic [31:0] prdata_nxt;
  logic [11:0] addr;
  logic mapped;
  logic [11:0] blink_ms_r, blink_ms_nxt;
  logic lit;

  assign addr = paddr[11:0];
  assign mapped = (paddr[31:12] == 20'h0) && (addr == idx_addr(lip_pkg::IDX_HEAR_THROUGH_LED_CONFIG) ||
                  addr == idx_addr(lip_pkg::IDX_QUIETING_LED_CONFIG) ||
                  addr == idx_addr(lip_pkg::IDX_OPERATING_MODE) || addr == idx_addr(lip_pkg::IDX_LED_STATUS));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    cfg_nxt = cfg_r;
    prdata_nxt = prdata;
    if (psel && penable && pwrite) begin
      if (addr == idx_addr(lip_pkg::IDX_HEAR_THROUGH_LED_CONFIG) && paddr[31:12] == 20'h0) begin
        cfg_nxt.hear_through_led_config = pwdata[7:0];
      end
      if (addr == idx_addr(lip_pkg::IDX_QUIETING_LED_CONFIG) && paddr[31:12] == 20'h0) begin
        cfg_nxt.quieting_led_config = pwdata[7:0];
      end
      if (addr == idx_addr(lip_pkg::IDX_OPERATING_MODE) && paddr[31:12] == 20'h0) begin
        cfg_nxt.mode = lip_pkg::lip_mode_e'(pwdata[1:0]);
      end
    end
    if (psel && !penable && !pwrite) begin
      prdata_nxt = 32'h0;
      if (paddr[31:12] == 20'h0) begin
        case (addr)
          idx_addr(lip_pkg::IDX_HEAR_THROUGH_LED_CONFIG): prdata_nxt = {24'h0, cfg_r.hear_through_led_config};
          idx_addr(lip_pkg::IDX_QUIETING_LED_CONFIG): prdata_nxt = {24'h0, cfg_r.quieting_led_config};
          idx_addr(lip_pkg::IDX_OPERATING_MODE): prdata_nxt = {30'h0, cfg_r.mode};
          idx_addr(lip_pkg::IDX_LED_STATUS): prdata_nxt = {18'h0, blink_ms_r, lit, led_current_sink};
          default: prdata_nxt = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '{mode: lip_pkg::MODE_NONE, hear_through_led_config: lip_pkg::RST_LED_CONFIG,
                 quieting_led_config: lip_pkg::RST_LED_CONFIG};
      prdata <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      prdata <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective duty, pattern and restart key
  logic [1:0] ht_duty, q_duty, ht_pat_q, third_sel, eff_duty;
  logic [2:0] ht_pat;
  logic steady, dark, use_hear;
  logic [11:0] off_ms, period_ms;
  logic [10:0] key, key_r;
  logic restart;

  assign ht_duty = cfg_r.hear_through_led_config[lip_pkg::HT_DUTY_LSB +: 2];
  assign ht_pat = cfg_r.hear_through_led_config[lip_pkg::HT_PATTERN_LSB +: 3];
  assign q_duty = cfg_r.quieting_led_config[lip_pkg::Q_DUTY_LSB +: 2];
  assign ht_pat_q = cfg_r.quieting_led_config[lip_pkg::Q_PATTERN_LSB +: 2];
  assign third_sel = cfg_r.quieting_led_config[lip_pkg::THIRD_SEL_LSB +: 2];
  assign key = {cfg_r.mode, third_sel, ht_pat_q, ht_pat, ht_duty == lip_pkg::DUTY_OFF, q_duty == lip_pkg::DUTY_OFF};

  always_comb begin
    eff_duty = lip_pkg::DUTY_OFF;
    use_hear = 1'b0;
    dark = 1'b0;
    case (cfg_r.mode)
      lip_pkg::MODE_QUIETING: eff_duty = q_duty;
      lip_pkg::MODE_HEAR_THROUGH: begin
        eff_duty = ht_duty;
        use_hear = 1'b1;
      end
      lip_pkg::MODE_THIRD: begin
        eff_duty = lip_pkg::DUTY_QUARTER;
        use_hear = (third_sel == lip_pkg::THIRD_AS_HEAR);
        dark = (third_sel == lip_pkg::THIRD_DARK);
      end
      default: dark = 1'b1;
    endcase
    if (use_hear) begin
      steady = (ht_pat == 3'h0);
      off_ms = 12'(ht_pat * lip_pkg::BLINK_ON_MS);
    end else begin
      steady = (ht_pat_q == 2'h0);
      case (ht_pat_q)
        2'h1: off_ms = lip_pkg::Q_OFF1_MS;
        2'h2: off_ms = lip_pkg::Q_OFF2_MS;
        2'h3: off_ms = lip_pkg::Q_OFF3_MS;
        default: off_ms = 12'h000;
      endcase
    end
    if (cfg_r.mode == lip_pkg::MODE_THIRD && third_sel == lip_pkg::THIRD_ALWAYS) begin
      steady = 1'b1;
    end
    period_ms = 12'(lip_pkg::BLINK_ON_MS + off_ms);
  end

  assign restart = (key != key_r);
  assign lit = !dark && (steady || blink_ms_r < lip_pkg::BLINK_ON_MS);

  ////////////////////////////////////////////////////////////////////////////
  // counters and sink output
  logic [13:0] ms_cnt_r, ms_cnt_nxt;
  logic [7:0] pwm_cnt_r, pwm_cnt_nxt;
  logic ms_tick, sink_nxt;

  assign ms_tick = (ms_cnt_r == 14'(MS_CYCLES - 1));

  always_comb begin
    ms_cnt_nxt = ms_tick ? 14'h0000 : 14'(ms_cnt_r + 14'h0001);
    pwm_cnt_nxt = (pwm_cnt_r == 8'(lip_pkg::PWM_PERIOD_CYC - 8'h01)) ? 8'h00 : 8'(pwm_cnt_r + 8'h01);
    blink_ms_nxt = blink_ms_r;
    if (ms_tick) begin
      blink_ms_nxt = (blink_ms_r >= 12'(period_ms - 12'h001)) ? 12'h000 : 12'(blink_ms_r + 12'h001);
    end
    if (restart) begin
      ms_cnt_nxt = 14'h0000;
      pwm_cnt_nxt = 8'h00;
      blink_ms_nxt = 12'h000;
    end
    sink_nxt = lit && pwm_high(eff_duty, pwm_cnt_r);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 14'h0000;
      pwm_cnt_r <= 8'h00;
      blink_ms_r <= 12'h000;
      key_r <= 11'h000;
      led_current_sink <= 1'b0;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
      pwm_cnt_r <= pwm_cnt_nxt;
      blink_ms_r <= blink_ms_nxt;
      key_r <= key;
      led_current_sink <= sink_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_pwm_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (pwm_cnt_r == 8'(lip_pkg::PWM_PERIOD_CYC - 8'h01) && !restart) |=> pwm_cnt_r == 8'h00)
    else $error("pwm period not 180 cycles");
  a_quarter_edge: assert property (@(posedge clock) disable iff (!rst_n)
    (lit && eff_duty == lip_pkg::DUTY_QUARTER && pwm_cnt_r == 8'(lip_pkg::PWM_QUARTER_CYC - 8'h01))
    |=> led_current_sink ##0 $past(lit)) else $error("quarter on short");
  a_quarter_fall: assert property (@(posedge clock) disable iff (!rst_n)
    (eff_duty == lip_pkg::DUTY_QUARTER && pwm_cnt_r == lip_pkg::PWM_QUARTER_CYC) |=> !led_current_sink)
    else $error("quarter on long");
  a_half_rise: assert property (@(posedge clock) disable iff (!rst_n)
    (lit && eff_duty == lip_pkg::DUTY_HALF && pwm_cnt_r == 8'(lip_pkg::PWM_HALF_CYC - 8'h01)) |=> led_current_sink)
    else $error("half on short");
  a_half_fall: assert property (@(posedge clock) disable iff (!rst_n)
    (eff_duty == lip_pkg::DUTY_HALF && pwm_cnt_r == lip_pkg::PWM_HALF_CYC) |=> !led_current_sink)
    else $error("half on long");
  a_full_on: assert property (@(posedge clock) disable iff (!rst_n)
    (lit && eff_duty == lip_pkg::DUTY_FULL) |=> led_current_sink) else $error("full duty not on");
  a_off_dark: assert property (@(posedge clock) disable iff (!rst_n)
    (eff_duty == lip_pkg::DUTY_OFF || !lit) |=> !led_current_sink) else $error("sink on while off");
  a_third_dark: assert property (@(posedge clock) disable iff (!rst_n)
    (cfg_r.mode == lip_pkg::MODE_THIRD && third_sel == lip_pkg::THIRD_DARK) |-> !lit)
    else $error("third mode not dark");
  a_ht_blink: assert property (@(posedge clock) disable iff (!rst_n)
    (use_hear && ht_pat != 3'h0 && blink_ms_r == lip_pkg::BLINK_ON_MS && !restart) |-> !lit)
    else $error("hear blink not dark");
  a_q_blink: assert property (@(posedge clock) disable iff (!rst_n)
    (!use_hear && !steady && blink_ms_r == lip_pkg::BLINK_ON_MS && !restart) |-> !lit)
    else $error("quieting blink not dark");
  a_ms_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (ms_tick && !restart) |=> ms_cnt_r == 14'h0000) else $error("ms divider not wrapped");
  a_restart_zero: assert property (@(posedge clock) disable iff (!rst_n)
    restart |=> (blink_ms_r == 12'h0 && pwm_cnt_r == 8'h0)) else $error("counters not restarted");

endmodule // lip_led_blinker
`default_nettype wire

// ---- testbench/led_indicator_pwm_blinker_test.sv ----
// led_indicator_pwm_blinker_test: self-checking bench for lip_led_blinker
// assumes the design under core/, a 10 MHz clock and an apb master of its own
`timescale 1ns/1ps
`default_nettype none
module led_indicator_pwm_blinker_test;
  typedef struct {logic [1:0] m; logic [7:0] ht; logic [7:0] q; int dly; int hi;} lip_row_s;
  localparam logic [31:0] A_HT = {22'h0, lip_pkg::IDX_HEAR_THROUGH_LED_CONFIG, 2'h0};
  localparam logic [31:0] A_Q = {22'h0, lip_pkg::IDX_QUIETING_LED_CONFIG, 2'h0};
  localparam logic [31:0] A_MD = {22'h0, lip_pkg::IDX_OPERATING_MODE, 2'h0};
  localparam logic [31:0] A_ST = {22'h0, lip_pkg::IDX_LED_STATUS, 2'h0};
  localparam logic [31:0] A_BAD = 32'h0000_0080;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic led_current_sink;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int hi;
  // mode, hear-through cfg, quieting cfg, wait, lit cycles per 180
  lip_row_s rows [20] = '{
    '{2'h1, 8'h00, 8'h00, 5, 0}, '{2'h1, 8'h00, 8'h01, 5, 40},
    '{2'h1, 8'h00, 8'h02, 5, 90}, '{2'h1, 8'h00, 8'h03, 5, 180},
    '{2'h2, 8'h01, 8'h00, 5, 40}, '{2'h2, 8'h02, 8'h00, 5, 90},
    '{2'h2, 8'h03, 8'h00, 5, 180}, '{2'h2, 8'h00, 8'h03, 5, 0},
    '{2'h2, 8'h05, 8'h00, 1000, 0}, '{2'h2, 8'h1F, 8'h00, 5000, 0},
    '{2'h2, 8'h1F, 8'h00, 6600, 180}, '{2'h1, 8'h00, 8'h07, 10000, 0},
    '{2'h1, 8'h00, 8'h07, 11000, 180}, '{2'h1, 8'h00, 8'h0F, 25000, 0},
    '{2'h3, 8'h00, 8'h60, 5, 40}, '{2'h3, 8'h03, 8'h03, 5, 0},
    '{2'h3, 8'h07, 8'h40, 5, 40}, '{2'h3, 8'h07, 8'h40, 1000, 0},
    '{2'h3, 8'h00, 8'h24, 1000, 0}, '{2'h0, 8'h03, 8'h03, 5, 0}
  };

  lip_led_blinker #(.MS_CYCLES(10)) u_dut (
    .clock(clock),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .led_current_sink(led_current_sink)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clock = ~clock;
  end

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic count_hi();
    hi = 0;
    repeat (180) begin
      @(posedge clock);
      if (led_current_sink === 1'b1) hi++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    check({31'h0, led_current_sink}, 32'h0);
    apb(1'b0, A_HT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, A_Q, 32'h0);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, A_MD, 32'h0);
      apb(1'b1, A_HT, {24'h0, rows[i].ht});
      apb(1'b1, A_Q, {24'h0, rows[i].q});
      apb(1'b1, A_MD, {30'h0, rows[i].m});
      repeat (rows[i].dly) @(posedge clock);
      count_hi();
      check(32'(hi), 32'(rows[i].hi));
    end
    // readback, unmapped access, reset in mid-run
    apb(1'b1, A_HT, 32'h0000_001D);
    apb(1'b0, A_HT, 32'h0);
    check(rd, 32'h0000_001D);
    check({31'h0, er}, 32'h0);
    check({31'h0, pready}, 32'h1);
    apb(1'b1, A_BAD, 32'h0000_00FF);
    check({31'h0, er}, 32'h1);
    apb(1'b0, A_BAD, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, A_MD, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, A_Q, 32'h0000_0003);
    apb(1'b1, A_MD, 32'h0000_0001);
    repeat (5) @(posedge clock);
    count_hi();
    check(32'(hi), 32'h0000_00B4);
    apb(1'b0, A_MD, 32'h0);
    check(rd, 32'h0000_0001);
    apb(1'b0, A_ST, 32'h0);
    check(rd & 32'h0000_0003, 32'h0000_0003);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    check({31'h0, led_current_sink}, 32'h0);
    rst_n <= 1'b1;
    apb(1'b0, A_Q, 32'h0);
    check(rd, 32'h0);
    finish_test();
  end
endmodule // led_indicator_pwm_blinker_test
`default_nettype wire
